// file: src/cmpf_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "cmpf_cfg.svh"
module cmpf_top #(
  parameter int N_CMP = `CMPF_N_CMP
) (
  input  wire logic             MCLK,
  input  wire logic             RESET_N,
  input  wire logic [11:0]      PADDR,
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [31:0]      PWDATA,
  output logic      [31:0]      PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  input  wire logic [N_CMP-1:0] CMP_RAW,
  output logic      [N_CMP-1:0] CMP_ENABLE,
  output logic      [N_CMP-1:0] CMP_REF_SEL,
  output logic      [N_CMP-1:0] CMP_RESULT,
  output logic                  IRQ,
  output logic                  WAKE
);
  cmpf_pkg::cmpf_ctl_t    ctl_ff [N_CMP];
  cmpf_pkg::cmpf_pmode_t  mode_ff;
  cmpf_pkg::cmpf_apb_req_t req;
  logic             pwr_dis_ff;
  logic [N_CMP-1:0] ien_ff;
  logic [N_CMP-1:0] result;
  logic [N_CMP-1:0] flag;
  logic [N_CMP-1:0] clr;
  logic [N_CMP-1:0] active;
  logic [N_CMP-1:0] irq_src;
  logic             wr;
  logic             rd;
  logic             bad;
  logic [31:0]      nxt_rdata;

  assign req = '{paddr: PADDR, psel: PSEL, penable: PENABLE, pwrite: PWRITE, pwdata: PWDATA};
  // Zero-wait slave: every access completes in the access cycle
  assign wr  = req.psel && req.penable && req.pwrite;
  assign rd  = req.psel && req.penable && !req.pwrite;

  always_comb begin
    bad = 1'b1;
    if (req.paddr == `CMPF_OFF_CFG0) bad = 1'b0;
    else if (req.paddr == `CMPF_OFF_CFG1) bad = (N_CMP < 2);
    else if (req.paddr == `CMPF_OFF_PWR) bad = 1'b0;
    else if (req.paddr == `CMPF_OFF_STAT) bad = 1'b0;
    else if (req.paddr == `CMPF_OFF_IEN) bad = 1'b0;
    else if (req.paddr == `CMPF_OFF_ICLR) bad = 1'b0;
    else if (req.paddr == `CMPF_OFF_MODE) bad = 1'b0;
  end

  generate
    for (genvar i = 0; i < N_CMP; i++) begin : g_ch
      logic cfg_hit;
      logic stat_clr;
      assign cfg_hit = wr && (req.paddr == (i == 0 ? `CMPF_OFF_CFG0 : `CMPF_OFF_CFG1));
      assign stat_clr = wr && (req.paddr == `CMPF_OFF_ICLR) && req.pwdata[i];
      // Flag cleared by writing zero in its config, or via clear register
      assign clr[i] = (cfg_hit && !req.pwdata[`CMPF_BIT_FLAG]) || stat_clr;
      // Total power-down and power bit override the enable
      assign active[i] = ctl_ff[i].enable && !pwr_dis_ff
                         && (mode_ff != cmpf_pkg::PM_TOTAL_PDOWN);
      always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
          ctl_ff[i] <= '0;
        end else if (cfg_hit) begin
          ctl_ff[i].enable     <= req.pwdata[`CMPF_BIT_EN];
          ctl_ff[i].ref_select <= req.pwdata[`CMPF_BIT_REFSEL];
          ctl_ff[i].int_enable <= req.pwdata[`CMPF_BIT_IE];
        end
      end
      cmpf_chan u_chan (
        .mclk      (MCLK),
        .reset_n   (RESET_N),
        .active    (active[i]),
        .raw_out   (CMP_RAW[i]),
        .flag_clr  (clr[i]),
        .result_ff (result[i]),
        .flag_ff   (flag[i]),
        .change    ()
      );
      assign irq_src[i] = flag[i] && ctl_ff[i].int_enable && ien_ff[i];
    end
  endgenerate

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) pwr_dis_ff <= 1'b0;
    else if (wr && req.paddr == `CMPF_OFF_PWR) pwr_dis_ff <= req.pwdata[`CMPF_BIT_PWRDIS];
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) ien_ff <= '0;
    else if (wr && req.paddr == `CMPF_OFF_IEN) ien_ff <= req.pwdata[N_CMP-1:0];
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) mode_ff <= cmpf_pkg::PM_ACTIVE;
    else if (wr && req.paddr == `CMPF_OFF_MODE) mode_ff <= cmpf_pkg::cmpf_pmode_t'(req.pwdata[1:0]);
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (req.paddr == `CMPF_OFF_CFG0 || (N_CMP > 1 && req.paddr == `CMPF_OFF_CFG1)) begin
      for (int i = 0; i < N_CMP; i++) begin
        if (req.paddr == (i == 0 ? `CMPF_OFF_CFG0 : `CMPF_OFF_CFG1)) begin
          nxt_rdata[`CMPF_BIT_EN]     = ctl_ff[i].enable;
          nxt_rdata[`CMPF_BIT_REFSEL] = ctl_ff[i].ref_select;
          nxt_rdata[`CMPF_BIT_IE]     = ctl_ff[i].int_enable;
          nxt_rdata[`CMPF_BIT_FLAG]   = flag[i];
          nxt_rdata[`CMPF_BIT_RESULT] = result[i];
        end
      end
    end else if (req.paddr == `CMPF_OFF_PWR) begin
      nxt_rdata[`CMPF_BIT_PWRDIS] = pwr_dis_ff;
    end else if (req.paddr == `CMPF_OFF_STAT) begin
      nxt_rdata[N_CMP-1:0] = flag;
    end else if (req.paddr == `CMPF_OFF_IEN) begin
      nxt_rdata[N_CMP-1:0] = ien_ff;
    end else if (req.paddr == `CMPF_OFF_MODE) begin
      nxt_rdata[1:0] = mode_ff;
    end
  end

  // Registered read data presented in the access cycle; setup cycle loads it
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) PRDATA <= 32'h0000_0000;
    else if (req.psel && !req.penable && !req.pwrite) PRDATA <= nxt_rdata;
    else if (rd) PRDATA <= PRDATA;
  end

  // Ready registered: high in the cycle after the setup cycle, low otherwise
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= req.psel && !req.penable;
      PSLVERR <= req.psel && !req.penable && bad;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CMP_ENABLE  <= '0;
      CMP_REF_SEL <= '0;
      CMP_RESULT  <= '1;
    end else begin
      CMP_ENABLE  <= active;
      for (int i = 0; i < N_CMP; i++) begin
        CMP_REF_SEL[i] <= ctl_ff[i].ref_select;
      end
      CMP_RESULT  <= result;
    end
  end

  // Wake is meaningless in total power-down as comparators are off there
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ  <= 1'b0;
      WAKE <= 1'b0;
    end else begin
      IRQ  <= |irq_src;
      WAKE <= |irq_src && (mode_ff == cmpf_pkg::PM_IDLE || mode_ff == cmpf_pkg::PM_PDOWN);
    end
  end
endmodule : cmpf_top
`default_nettype wire

// file: src/cmpf_cfg.svh
`ifndef CMPF_CFG_SVH
`define CMPF_CFG_SVH
`define CMPF_OFF_CFG0    12'h000
`define CMPF_OFF_CFG1    12'h004
`define CMPF_OFF_PWR     12'h008
`define CMPF_OFF_STAT    12'h00c
`define CMPF_OFF_IEN     12'h010
`define CMPF_OFF_ICLR    12'h014
`define CMPF_OFF_MODE    12'h018
`define CMPF_BIT_EN      0
`define CMPF_BIT_REFSEL  1
`define CMPF_BIT_IE      2
`define CMPF_BIT_FLAG    3
`define CMPF_BIT_RESULT  4
`define CMPF_BIT_PWRDIS  5
`define CMPF_RST_CFG     8'h00
`define CMPF_RST_PWR     8'h00
`define CMPF_N_CMP       2
`endif

// file: src/cmpf_pkg.sv
`default_nettype none
package cmpf_pkg;
  typedef enum logic [1:0] {
    PM_ACTIVE,
    PM_IDLE,
    PM_PDOWN,
    PM_TOTAL_PDOWN
  } cmpf_pmode_t;
  typedef struct packed {
    logic enable;
    logic ref_select;
    logic int_enable;
  } cmpf_ctl_t;
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } cmpf_apb_req_t;
endpackage : cmpf_pkg
`default_nettype wire

// file: src/cmpf_chan.sv
`timescale 1ns/100ps
`default_nettype none
module cmpf_chan (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic active,
  input  wire logic raw_out,
  input  wire logic flag_clr,
  output logic      result_ff,
  output logic      flag_ff,
  output logic      change
);
  logic sync1_ff;
  logic sync2_ff;
  logic nxt_result;
  // Pin sampled twice before any logic sees it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
    end else begin
      sync1_ff <= raw_out;
      sync2_ff <= sync1_ff;
    end
  end
  // Disabled channel reads high
  assign nxt_result = active ? sync2_ff : 1'b1;
  assign change     = nxt_result != result_ff;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) result_ff <= 1'b1;
    else          result_ff <= nxt_result;
  end
  // Set beats a simultaneous clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)    flag_ff <= 1'b0;
    else if (change) flag_ff <= 1'b1;
    else if (flag_clr) flag_ff <= 1'b0;
  end
endmodule : cmpf_chan
`default_nettype wire

// file: verif/cmpf_properties.sv
`timescale 1ns/100ps
`default_nettype none
module cmpf_properties #(parameter int N_CMP = 2) (
  input wire logic             MCLK,
  input wire logic             RESET_N,
  input wire logic             PSEL,
  input wire logic             PENABLE,
  input wire logic             PWRITE,
  input wire logic             PREADY,
  input wire logic             PSLVERR,
  input wire logic [N_CMP-1:0] CMP_RAW,
  input wire logic [N_CMP-1:0] CMP_ENABLE,
  input wire logic [N_CMP-1:0] CMP_RESULT,
  input wire logic             IRQ,
  input wire logic             WAKE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  wire logic  wr = PSEL && PENABLE && PWRITE;
  logic [3:0] recent_ff;
  // Interrupt may only follow a write or a result change
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) recent_ff <= 4'h0;
    else recent_ff <= {recent_ff[2:0], wr || (CMP_RESULT != $past(CMP_RESULT))};
  end
  sequence s_setup; PSEL && !PENABLE; endsequence
  sequence s_steady; (CMP_ENABLE[0] && $stable(CMP_RAW[0])) [*6]; endsequence
  property p_ready; s_setup |=> PREADY ##1 !PREADY; endproperty
  property p_err; PSLVERR |-> PREADY; endproperty
  property p_wake; WAKE |-> IRQ; endproperty
  // Write lands in the control state, the enable pin follows one edge later
  property p_en_rise; $rose(CMP_ENABLE[0]) |-> $past(wr, 2); endproperty
  property p_en_fall; $fell(CMP_ENABLE[0]) |-> $past(wr, 2); endproperty
  property p_forced; !CMP_ENABLE[0] [*3] |-> CMP_RESULT[0]; endproperty
  property p_follow; s_steady |-> CMP_RESULT[0] == CMP_RAW[0]; endproperty
  property p_irq;
    $rose(IRQ) |-> (|recent_ff) || (CMP_RESULT != $past(CMP_RESULT));
  endproperty
  a_ready: assert property (p_ready) else $error("pready timing wrong");
  a_err: assert property (p_err) else $error("pslverr without pready");
  a_wake: assert property (p_wake) else $error("wake without irq");
  a_en_rise: assert property (p_en_rise) else $error("enable rose unasked");
  a_en_fall: assert property (p_en_fall) else $error("enable fell unasked");
  a_forced: assert property (p_forced) else $error("disabled result low");
  a_follow: assert property (p_follow) else $error("result not raw");
  a_irq: assert property (p_irq) else $error("irq without cause");
endmodule : cmpf_properties
bind cmpf_top cmpf_properties #(.N_CMP(N_CMP)) cmpf_properties_inst (.*);
`default_nettype wire

// file: verif/cmpf_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module cmpf_core_model #(parameter logic [7:0] VREF = 8'h80) (
  input  wire logic            MCLK,
  input  wire logic [1:0]      CMP_ENABLE,
  input  wire logic [1:0]      CMP_REF_SEL,
  input  wire logic [1:0][7:0] PLUS,
  input  wire logic [1:0][7:0] PIN,
  output logic      [1:0]      CMP_RAW
);
  initial CMP_RAW = 2'h0;
  // Unpowered core gives no steady level
  // Output always driven hard, never released
  always @(posedge MCLK) begin
    for (int i = 0; i < 2; i++) begin
      CMP_RAW[i] <= CMP_ENABLE[i] ? PLUS[i] > (CMP_REF_SEL[i] ? VREF : PIN[i]) : ~CMP_RAW[i];
    end
  end
endmodule : cmpf_core_model
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic            MCLK = 1'b0, RESET_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0]     PADDR = 12'h000;
  logic [31:0]     PWDATA = 32'h0, PRDATA, rd, seed = 32'h00014b71;
  logic            PREADY, PSLVERR, IRQ, WAKE, err;
  logic [1:0]      CMP_RAW, CMP_ENABLE, CMP_REF_SEL, CMP_RESULT, prev;
  logic [1:0][7:0] PLUS = 16'h0, PIN = 16'h0;
  int              num_errors = 0, total_checks = 0;
  always #5 MCLK = ~MCLK;
  cmpf_top #(.N_CMP(2)) cmpf_top_inst (.*);
  cmpf_core_model #(.VREF(8'h80)) cmpf_core_model_inst (.*);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  // Comparator 0 on the reference, comparator 1 on its pin
  function automatic logic [1:0] expr(input logic [1:0][7:0] p, input logic [1:0][7:0] n);
    return {p[1] > n[1], p[0] > 8'h80};
  endfunction : expr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge MCLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, w, a, d};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rd = PRDATA;
    err = PSLVERR;
    if (n >= 20) chk(32'h0, 32'h1);
    {PSEL, PENABLE} <= 2'b00;
  endtask : apb
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge MCLK);
    RESET_N <= 1'b1;
    chk(32'(CMP_RESULT), 32'h3);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h10);
    apb(1'b0, 12'h01c, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    $display("test reset done");
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b1, 12'h010, 32'h1);
    repeat (10) @(posedge MCLK);
    apb(1'b1, 12'h014, 32'h3);
    chk(32'(CMP_REF_SEL), 32'h1);
    prev = 2'b00;
    for (int k = 0; k < 12; k++) begin
      seed = xs(seed);
      if (k < 2) seed[7:0] = 8'h80 + 8'(k);
      PLUS <= seed[15:0];
      PIN <= seed[31:16];
      repeat (10) @(posedge MCLK);
      chk(32'(CMP_RESULT), 32'(expr(seed[15:0], seed[31:16])));
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd, 32'(prev ^ expr(seed[15:0], seed[31:16])));
      chk(32'(IRQ), 32'h0);
      prev = expr(seed[15:0], seed[31:16]);
      apb(1'b1, 12'h014, 32'h3);
    end
    $display("test compare done");
    apb(1'b1, 12'h000, 32'h7);
    apb(1'b1, 12'h018, 32'h1);
    PLUS[0] <= prev[0] ? 8'h00 : 8'hff;
    repeat (10) @(posedge MCLK);
    chk(32'(IRQ), 32'h1);
    chk(32'(WAKE), 32'h1);
    apb(1'b1, 12'h010, 32'h0);
    repeat (2) @(posedge MCLK);
    chk(32'(IRQ), 32'h0);
    PLUS[0] <= 8'h00;
    repeat (10) @(posedge MCLK);
    apb(1'b1, 12'h014, 32'h3);
    apb(1'b1, 12'h010, 32'h1);
    repeat (2) @(posedge MCLK);
    chk(32'(IRQ), 32'h0);
    apb(1'b1, 12'h000, 32'h4);
    repeat (8) @(posedge MCLK);
    chk(32'(CMP_RESULT[0]), 32'h1);
    chk(32'(IRQ), 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 12'h014, 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0);
    chk(32'(IRQ), 32'h0);
    $display("test interrupt done");
    apb(1'b1, 12'h018, 32'h2);
    repeat (2) @(posedge MCLK);
    chk(32'(CMP_ENABLE), 32'h2);
    apb(1'b1, 12'h018, 32'h3);
    repeat (2) @(posedge MCLK);
    chk(32'(CMP_ENABLE), 32'h0);
    apb(1'b1, 12'h018, 32'h0);
    apb(1'b1, 12'h008, 32'h20);
    repeat (2) @(posedge MCLK);
    chk(32'(CMP_ENABLE), 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h20);
    $display("test power done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
